// ### dmas_map.svh
// Constants, field positions and register map of the multiply-add slice.
// Contract
// - One 20-bit control word carries operand, function, carry, carry source, path.
// - Carry output: one bit single, two bits dual, four bits quad mode.
// - Adder runs as one 48-bit, two 24-bit or four 12-bit lanes.
// - Dynamic mode switches per cycle between product and concatenation of A,B.
// - Pre-adder forms D plus or minus A, or routes A to the multiplier.
// - Auto-reset clears P the cycle after a pattern match.
// - Pattern is compared for equality, taken from C or a constant.
// - Mask from C or a constant hides bits from the comparison.
// - Match output is 1 when masked result equals the pattern, else 0.
// - Inverse match output is 1 when result equals the inverted pattern.
// - Overflow flags growth beyond P[N]; N from mask ones, 1 to 46.
// - Underflow flags results below minus P[N], same N.
// - An absent C input reads as zero.
// - The global reset drives every pipeline register reset.
// - The global enable drives every pipeline register enable.
// - A comes from direct input or A cascade, cascade fed by a slice.
// - B comes from direct input or B cascade, cascade fed by a slice.
// - Sign cascade output feeds a neighbour's sign input for 96-bit sums.
// - A input register depth is configurable; zero passes A straight through.
// - A cascade output depth is separate, zero allowed, never above A depth.
// - B depth applies equally to direct and cascade B.
// - A high dedicated reset at a clock edge clears the P register.
`ifndef DMAS_MAP_SVH
`define DMAS_MAP_SVH
`define DMAS_CFG_OFF   8'h00
`define DMAS_PATL_OFF  8'h04
`define DMAS_PATH_OFF  8'h08
`define DMAS_MSKL_OFF  8'h0C
`define DMAS_MSKH_OFF  8'h10
`define DMAS_STAT_OFF  8'h14
`define DMAS_CFG_RST   32'h0000_0200
`define DMAS_PAT_RST   48'h0000_0000_0000
`define DMAS_MSK_RST   48'h0000_0000_0000
`define DMAS_CFG_ASEL  0
`define DMAS_CFG_BSEL  1
`define DMAS_CFG_SIMD  2
`define DMAS_CFG_DYN   4
`define DMAS_CFG_PRE   5
`define DMAS_CFG_AUTO  6
`define DMAS_CFG_PATC  7
`define DMAS_CFG_MSKC  8
`define DMAS_CFG_CPRES 9
`define DMAS_CFG_ADEP  10
`define DMAS_CFG_ACDEP 12
`define DMAS_CFG_BDEP  14
`define DMAS_CFG_BCDEP 16
`define DMAS_OPM_LO    0
`define DMAS_ALU_LO    7
`define DMAS_CIN_BIT   11
`define DMAS_CSEL_LO   12
`define DMAS_INM_LO    15
`define DMAS_INM_SUB   3
`define DMAS_X_LO      0
`define DMAS_Y_LO      2
`define DMAS_Z_LO      4
`define DMAS_X_M       2'h1
`define DMAS_X_P       2'h2
`define DMAS_X_AB      2'h3
`define DMAS_Y_C       2'h3
`define DMAS_Z_PCIN    3'h1
`define DMAS_Z_P       3'h2
`define DMAS_Z_C       3'h3
`define DMAS_Z_SIGN    3'h6
`define DMAS_CSEL_PCIN 3'h1
`define DMAS_LANE_W    12
`define DMAS_LANES     4
`define DMAS_N_MIN     6'h01
`define DMAS_N_MAX     6'h2E
`define DMAS_RESP_OK   2'h0
`define DMAS_RESP_ERR  2'h2
`endif

// ### dmas_pkg.sv
// Types shared by the multiply-add slice.
package dmas_pkg;
  typedef enum logic [1:0] {
    SIMD_ONE48  = 2'h0,
    SIMD_TWO24  = 2'h1,
    SIMD_FOUR12 = 2'h2
  } dmas_simd_t;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0,
    ALU_SUB = 4'h3,
    ALU_XOR = 4'h4,
    ALU_AND = 4'hC,
    ALU_OR  = 4'hE
  } dmas_aluop_t;
endpackage

// ### dmas_pipe.sv
// Input delay line with selectable depth and a shallower cascade tap.
`timescale 1ns/1ps
module dmas_pipe #(
  parameter int W = 30
) (
  // Clock, resets and enable
  input  logic         aclk,
  input  logic         aresetn,
  input  logic         rst,
  input  logic         en,
  // Data and depths
  input  logic [W-1:0] d,
  input  logic [1:0]   depth,
  input  logic [1:0]   tap_depth,
  output logic [W-1:0] q,
  output logic [W-1:0] tap
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [1:0]   tdep;

  always_ff @(posedge aclk) begin
    if (!aresetn || rst) begin
      s1 <= '0;
      s2 <= '0;
    end else if (en) begin
      s1 <= d;
      s2 <= s1;
    end
  end

  assign tdep = (tap_depth > depth) ? depth : tap_depth;
  assign q    = (depth == 2'h0) ? d : (depth == 2'h1) ? s1 : s2;
  assign tap  = (tdep == 2'h0) ? d : (tdep == 2'h1) ? s1 : s2;
endmodule

// ### dmas_alu.sv
// Three-operand adder and logic unit, splittable into SIMD lanes.
`timescale 1ns/1ps
`include "dmas_map.svh"
module dmas_alu (
  // Operands
  input  logic [47:0]          x,
  input  logic [47:0]          y,
  input  logic [47:0]          z,
  input  logic                 cin,
  // Mode
  input  dmas_pkg::dmas_aluop_t op,
  input  dmas_pkg::dmas_simd_t  simd,
  // Result
  output logic [47:0]          r,
  output logic [3:0]           cout
);
  logic [47:0] zz;
  logic [47:0] sum;
  logic [13:0] sec [`DMAS_LANES];
  logic [3:0]  co;

  // Subtract uses Z-(X+Y+cin) = ~(~Z+X+Y+cin).
  assign zz = (op == dmas_pkg::ALU_SUB) ? ~z : z;

  // Carry chain broken at lane edges.
  for (genvar i = 0; i < `DMAS_LANES; i++) begin : g_sec
    logic       brk;
    logic [1:0] ci;
    assign brk = (i == 0) || (simd == dmas_pkg::SIMD_FOUR12) ||
                 ((simd == dmas_pkg::SIMD_TWO24) && (i == 2));
    if (i == 0) begin : g_c0
      assign ci = {1'b0, cin};
    end else begin : g_cn
      assign ci = brk ? {1'b0, cin} : sec[i-1][13:12];
    end
    assign sec[i] = {2'h0, zz[i*`DMAS_LANE_W +: `DMAS_LANE_W]}
                  + {2'h0, x[i*`DMAS_LANE_W +: `DMAS_LANE_W]}
                  + {2'h0, y[i*`DMAS_LANE_W +: `DMAS_LANE_W]}
                  + {12'h000, ci};
    assign sum[i*`DMAS_LANE_W +: `DMAS_LANE_W] = sec[i][11:0];
    assign co[i] = |sec[i][13:12];
  end

  always_comb begin
    case (op)
      dmas_pkg::ALU_SUB: r = ~sum;
      dmas_pkg::ALU_XOR: r = x ^ z;
      dmas_pkg::ALU_AND: r = x & z;
      dmas_pkg::ALU_OR:  r = x | z;
      default:           r = sum;
    endcase
  end

  always_comb begin
    case (simd)
      dmas_pkg::SIMD_FOUR12: cout = co;
      dmas_pkg::SIMD_TWO24:  cout = {2'h0, co[3], co[1]};
      default:               cout = {3'h0, co[3]};
    endcase
  end
endmodule

// ### dmas_top.sv
// Multiply, pre-add and add/logic slice with pattern detect and AXI config.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "dmas_map.svh"
module dmas_top (
  // Clock and bus reset
  input  logic        aclk,
  input  logic        aresetn,
  // AXI4-Lite write
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  // AXI4-Lite read
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  // Global and dedicated resets, enable
  input  logic        rst,
  input  logic        rst_p,
  input  logic        en,
  // Fabric operands and control word
  input  logic [29:0] a,
  input  logic [17:0] b,
  input  logic [47:0] c,
  input  logic [24:0] d,
  input  logic [19:0] ctrl,
  // Cascade inputs
  input  logic [29:0] acin,
  input  logic [17:0] bcin,
  input  logic [47:0] pcin,
  input  logic        multsign_in,
  // Results
  output logic [47:0] p,
  output logic [3:0]  carryout,
  output logic        pattern_match,
  output logic        pattern_bar,
  output logic        overflow,
  output logic        underflow,
  // Cascade outputs
  output logic [29:0] acout,
  output logic [17:0] bcout,
  output logic [47:0] pcout,
  output logic        multsign_out
);
  logic [31:0] cfg;
  logic [47:0] pat_cfg;
  logic [47:0] msk_cfg;
  logic [29:0] a_src;
  logic [17:0] b_src;
  logic [29:0] a_q;
  logic [17:0] b_q;
  logic [24:0] ad;
  logic [24:0] mult_a;
  logic signed [42:0] prod;
  logic [47:0] m_reg;
  logic [47:0] c_op;
  logic [47:0] x_op;
  logic [47:0] y_op;
  logic [47:0] z_op;
  logic        cin;
  logic [47:0] alu_r;
  logic [3:0]  alu_co;
  logic [47:0] pat_sel;
  logic [47:0] msk_sel;
  logic        match_now;
  logic        bar_now;
  logic [5:0]  n_ones;
  logic [5:0]  n_sh;
  logic        ovf_now;
  logic        unf_now;
  logic        p_clr;
  logic        wr_fire;
  logic        rd_fire;
  logic [1:0]  xsel;
  logic [1:0]  ysel;
  logic [2:0]  zsel;
  logic [2:0]  csel;
  logic [4:0]  inm;
  logic [31:0] pat_hi_new;
  logic [31:0] msk_hi_new;
  dmas_pkg::dmas_aluop_t aluop;
  dmas_pkg::dmas_simd_t  simd;

  // Bytes of a write land only where the strobe is set.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] v;
    v = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        v[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] ad_in);
    return (ad_in == `DMAS_CFG_OFF) || (ad_in == `DMAS_PATL_OFF) ||
           (ad_in == `DMAS_PATH_OFF) || (ad_in == `DMAS_MSKL_OFF) ||
           (ad_in == `DMAS_MSKH_OFF) || (ad_in == `DMAS_STAT_OFF);
  endfunction

  function automatic logic [5:0] ones(input logic [47:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int k = 0; k < 48; k++) begin
      n = n + {5'h00, m[k]};
    end
    return n;
  endfunction

  // Write address and data are taken together in one handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                 !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
  end

  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DMAS_RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(s_axi_awaddr) ? `DMAS_RESP_OK
                                           : `DMAS_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // The upper pattern and mask words keep only their low 16 bits.
  assign pat_hi_new = merge({16'h0000, pat_cfg[47:32]}, s_axi_wdata,
                            s_axi_wstrb);
  assign msk_hi_new = merge({16'h0000, msk_cfg[47:32]}, s_axi_wdata,
                            s_axi_wstrb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg     <= `DMAS_CFG_RST;
      pat_cfg <= `DMAS_PAT_RST;
      msk_cfg <= `DMAS_MSK_RST;
    end else if (wr_fire) begin
      case (s_axi_awaddr)
        `DMAS_CFG_OFF:
          cfg <= merge(cfg, s_axi_wdata, s_axi_wstrb);
        `DMAS_PATL_OFF:
          pat_cfg[31:0] <= merge(pat_cfg[31:0], s_axi_wdata, s_axi_wstrb);
        `DMAS_PATH_OFF:
          pat_cfg[47:32] <= pat_hi_new[15:0];
        `DMAS_MSKL_OFF:
          msk_cfg[31:0] <= merge(msk_cfg[31:0], s_axi_wdata, s_axi_wstrb);
        `DMAS_MSKH_OFF:
          msk_cfg[47:32] <= msk_hi_new[15:0];
        default: ;
      endcase
    end
  end

  assign rd_fire = s_axi_arready && s_axi_arvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DMAS_RESP_OK;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `DMAS_RESP_OK
                                           : `DMAS_RESP_ERR;
      case (s_axi_araddr)
        `DMAS_CFG_OFF:  s_axi_rdata <= cfg;
        `DMAS_PATL_OFF: s_axi_rdata <= pat_cfg[31:0];
        `DMAS_PATH_OFF: s_axi_rdata <= {16'h0000, pat_cfg[47:32]};
        `DMAS_MSKL_OFF: s_axi_rdata <= msk_cfg[31:0];
        `DMAS_MSKH_OFF: s_axi_rdata <= {16'h0000, msk_cfg[47:32]};
        `DMAS_STAT_OFF: s_axi_rdata <= {24'h000000, carryout, overflow,
                                        underflow, pattern_bar,
                                        pattern_match};
        default:        s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign xsel  = ctrl[`DMAS_OPM_LO + `DMAS_X_LO +: 2];
  assign ysel  = ctrl[`DMAS_OPM_LO + `DMAS_Y_LO +: 2];
  assign zsel  = ctrl[`DMAS_OPM_LO + `DMAS_Z_LO +: 3];
  assign aluop = dmas_pkg::dmas_aluop_t'(ctrl[`DMAS_ALU_LO +: 4]);
  assign csel  = ctrl[`DMAS_CSEL_LO +: 3];
  assign inm   = ctrl[`DMAS_INM_LO +: 5];
  assign simd  = dmas_pkg::dmas_simd_t'(cfg[`DMAS_CFG_SIMD +: 2]);

  assign a_src = cfg[`DMAS_CFG_ASEL] ? acin : a;
  assign b_src = cfg[`DMAS_CFG_BSEL] ? bcin : b;

  // A path depth and cascade tap.
  dmas_pipe #(.W(30)) u_apipe (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .rst       (rst),
    .en        (en),
    .d         (a_src),
    .depth     (cfg[`DMAS_CFG_ADEP +: 2]),
    .tap_depth (cfg[`DMAS_CFG_ACDEP +: 2]),
    .q         (a_q),
    .tap       (acout)
  );

  // One B delay for both sources.
  dmas_pipe #(.W(18)) u_bpipe (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .rst       (rst),
    .en        (en),
    .d         (b_src),
    .depth     (cfg[`DMAS_CFG_BDEP +: 2]),
    .tap_depth (cfg[`DMAS_CFG_BCDEP +: 2]),
    .q         (b_q),
    .tap       (bcout)
  );

  assign ad     = inm[`DMAS_INM_SUB] ? (d - a_q[24:0]) : (d + a_q[24:0]);
  assign mult_a = cfg[`DMAS_CFG_PRE] ? ad : a_q[24:0];
  assign prod   = $signed(mult_a) * $signed(b_q);

  // Product and, in dynamic mode, concatenation share one stage.
  always_ff @(posedge aclk) begin
    if (!aresetn || rst) begin
      m_reg <= 48'h0000_0000_0000;
    end else if (en) begin
      if (cfg[`DMAS_CFG_DYN] && (xsel == `DMAS_X_AB)) begin
        m_reg <= {a_q, b_q};
      end else begin
        m_reg <= {{5{prod[42]}}, prod};
      end
    end
  end

  assign c_op = cfg[`DMAS_CFG_CPRES] ? c : 48'h0000_0000_0000;

  always_comb begin
    case (xsel)
      `DMAS_X_M:  x_op = m_reg;
      `DMAS_X_P:  x_op = p;
      `DMAS_X_AB: x_op = cfg[`DMAS_CFG_DYN] ? m_reg : {a_q, b_q};
      default:    x_op = 48'h0000_0000_0000;
    endcase
  end

  assign y_op = (ysel == `DMAS_Y_C) ? c_op : 48'h0000_0000_0000;

  // P cascade data enters on the Z path; its inverted top bit feeds the carry-in when the carry source selects it.
  always_comb begin
    case (zsel)
      `DMAS_Z_PCIN: z_op = pcin;
      `DMAS_Z_P:    z_op = p;
      `DMAS_Z_C:    z_op = c_op;
      `DMAS_Z_SIGN: z_op = {48{multsign_in}};
      default:      z_op = 48'h0000_0000_0000;
    endcase
  end

  assign cin = (csel == `DMAS_CSEL_PCIN) ? ~pcin[47]
                                         : ctrl[`DMAS_CIN_BIT];

  dmas_alu u_alu (
    .x    (x_op),
    .y    (y_op),
    .z    (z_op),
    .cin  (cin),
    .op   (aluop),
    .simd (simd),
    .r    (alu_r),
    .cout (alu_co)
  );

  assign pat_sel   = cfg[`DMAS_CFG_PATC] ? c_op : pat_cfg;
  // Mask source; set bits are ignored.
  assign msk_sel   = cfg[`DMAS_CFG_MSKC] ? c_op : msk_cfg;
  assign match_now = ((alu_r ^ pat_sel) & ~msk_sel) == 48'h0000_0000_0000;
  assign bar_now   = ((alu_r ^ ~pat_sel) & ~msk_sel) == 48'h0000_0000_0000;

  assign n_ones  = ones(msk_sel);
  assign n_sh    = (n_ones < `DMAS_N_MIN) ? `DMAS_N_MIN :
                   (n_ones > `DMAS_N_MAX) ? `DMAS_N_MAX : n_ones;
  assign ovf_now = !alu_r[47] && (|(alu_r >> n_sh));
  // Below minus two to the N.
  assign unf_now = alu_r[47] && !(&($signed(alu_r) >>> n_sh));

  assign p_clr = cfg[`DMAS_CFG_AUTO] && pattern_match;

  // Global and dedicated resets clear P and flags.
  always_ff @(posedge aclk) begin
    if (!aresetn || rst || rst_p || p_clr) begin
      p             <= 48'h0000_0000_0000;
      carryout      <= 4'h0;
      pattern_match <= 1'b0;
      pattern_bar   <= 1'b0;
      overflow      <= 1'b0;
      underflow     <= 1'b0;
    end else if (en) begin
      p             <= alu_r;
      carryout      <= alu_co;
      pattern_match <= match_now;
      pattern_bar   <= bar_now;
      overflow      <= ovf_now;
      underflow     <= unf_now;
    end
  end

  assign pcout = p;

  always_ff @(posedge aclk) begin
    if (!aresetn || rst) begin
      multsign_out <= 1'b0;
    end else if (en) begin
      multsign_out <= m_reg[47];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rst_clears_all: assert property (
    rst |=> (p == 48'h0000_0000_0000) && (m_reg == 48'h0000_0000_0000)
            && !pattern_match)
    else $error("global reset left a pipeline register set");

  a_prst_clears_p: assert property (
    rst_p |=> (p == 48'h0000_0000_0000) && (carryout == 4'h0))
    else $error("dedicated reset did not clear P");

  a_auto_reset_p: assert property (
    (cfg[`DMAS_CFG_AUTO] && pattern_match) |=>
      (p == 48'h0000_0000_0000) && !pattern_match)
    else $error("P not cleared after pattern match");

  a_enable_holds: assert property (
    (!en && !rst && !rst_p && !p_clr) |=>
      $stable(p) && $stable(m_reg) && $stable(multsign_out))
    else $error("register moved while enable low");

  a_match_flag: assert property (
    (en && !rst && !rst_p && !p_clr) |=>
      pattern_match == (((p ^ $past(pat_sel)) & ~$past(msk_sel))
                        == 48'h0000_0000_0000))
    else $error("match flag disagrees with result");

  a_bar_flag: assert property (
    (en && !rst && !rst_p && !p_clr) |=>
      pattern_bar == (((p ^ ~$past(pat_sel)) & ~$past(msk_sel))
                      == 48'h0000_0000_0000))
    else $error("inverse match flag disagrees with result");

  a_carry_single: assert property (
    (simd == dmas_pkg::SIMD_ONE48) |=> (carryout[3:1] == 3'h0))
    else $error("upper carry bits set in single lane mode");

  a_acout_depth: assert property (
    (cfg[`DMAS_CFG_ADEP +: 2] != 2'h0 && cfg[`DMAS_CFG_ACDEP +: 2] == 2'h1
     && en && !rst) ##1 $stable(cfg) |-> acout == $past(a_src))
    else $error("A cascade output delay wrong");

  a_dyn_concat: assert property (
    (cfg[`DMAS_CFG_DYN] && xsel == `DMAS_X_AB && en && !rst) |=>
      m_reg == {$past(a_q), $past(b_q)})
    else $error("concatenation missing from multiplier stage");
endmodule

// ### dmas_nbr.sv
// Neighbouring slice model that feeds the cascade inputs of the slice.
`timescale 1ns/1ps
module dmas_nbr (
  // Clock
  input  logic        aclk,
  // Values the neighbour has formed
  input  logic [29:0] a_src,
  input  logic [17:0] b_src,
  input  logic [47:0] p_src,
  input  logic        s_src,
  // Cascade outputs toward the slice
  output logic [29:0] acout,
  output logic [17:0] bcout,
  output logic [47:0] pcout,
  output logic        sign_out
);
  always_ff @(posedge aclk) begin
    acout <= a_src;
    bcout <= b_src;
  end
  always_ff @(posedge aclk) begin
    pcout <= p_src;
  end
  always_ff @(posedge aclk) begin
    sign_out <= s_src;
  end
endmodule

// ### dmas_top_bench.sv
// Self-checking bench for the multiply-add slice.
`timescale 1ns/1ps
`include "dmas_map.svh"
module dmas_top_bench;
  logic        aclk = 1'h0, aresetn = 1'h0, rst = 1'h0, rst_p = 1'h0;
  logic        en = 1'h1, s_n = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [29:0] a = 30'h0, a_n = 30'h7, acin, acout;
  logic [17:0] b = 18'h0, b_n = 18'h6, bcin, bcout;
  logic [47:0] c = 48'h0, p_n = 48'h5, pcin, p, pcout;
  logic [24:0] d = 25'h0;
  logic [19:0] ctrl = 20'h0;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  carryout;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, multsign_in, multsign_out;
  logic        pattern_match, pattern_bar, overflow, underflow;
  int          errors = 0, checks = 0, cycles = 0;

  always #20 aclk = ~aclk;

  dmas_top dmas_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rst, .rst_p, .en, .a, .b, .c, .d, .ctrl,
    .acin, .bcin, .pcin, .multsign_in, .p, .carryout, .pattern_match,
    .pattern_bar, .overflow, .underflow, .acout, .bcout, .pcout,
    .multsign_out);

  dmas_nbr dmas_nbr_inst (.aclk, .a_src(a_n), .b_src(b_n), .p_src(p_n),
    .s_src(s_n), .acout(acin), .bcout(bcin), .pcout(pcin),
    .sign_out(multsign_in));

  task give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task chk(input string n, input logic [47:0] g, input logic [47:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task at(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
  endtask

  task rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
  endtask

  task t_regs();
    rd(`DMAS_CFG_OFF, 32'h200, `DMAS_RESP_OK);
    rd(8'h3C, 32'h0, `DMAS_RESP_ERR);
    wr(8'h3C, 32'h1, `DMAS_RESP_ERR);
    wr(`DMAS_STAT_OFF, 32'hFF, `DMAS_RESP_OK);
    wr(`DMAS_PATH_OFF, 32'hFFFFFFFF, `DMAS_RESP_OK);
    rd(`DMAS_PATH_OFF, 32'hFFFF, `DMAS_RESP_OK);
    wr(`DMAS_PATH_OFF, 32'h0, `DMAS_RESP_OK);
    $display("t_regs done");
  endtask

  // One-cycle operand pulse so that a wrong depth shows as a wrong P.
  task mul(input logic [31:0] cf, input logic [19:0] ct, input logic [29:0] av,
           input logic [17:0] bv, input logic [24:0] dv, input int lat,
           input logic [47:0] ex);
    wr(`DMAS_CFG_OFF, cf, `DMAS_RESP_OK);
    @(posedge aclk);
    ctrl <= ct;
    a <= av;
    b <= bv;
    d <= dv;
    @(posedge aclk);
    a <= 30'h0;
    b <= 18'h0;
    d <= 25'h0;
    at(lat - 1);
    chk("p", p, ex);
  endtask

  task t_simd();
    logic [47:0] ep [3] = '{48'h001001001000, 48'h001000001000, 48'h0};
    logic [3:0]  ec [3] = '{4'h1, 4'h3, 4'hF};
    for (int i = 0; i < 3; i++) begin
      wr(`DMAS_CFG_OFF, 32'h200 | (i << 2), `DMAS_RESP_OK);
      @(posedge aclk);
      ctrl <= 20'h3C;
      c <= 48'h800800800800;
      at(1);
      chk("p", p, ep[i]);
      chk("carryout", carryout, ec[i]);
    end
    $display("t_simd done");
  endtask

  task t_pat();
    logic [47:0] cv [4] = '{48'h5A, 48'hFFFFFFFFFF00, 48'h100, 48'hFFFFFFFFFEFF};
    logic [3:0]  ef [4] = '{4'h1, 4'h2, 4'h8, 4'h4};
    wr(`DMAS_CFG_OFF, 32'h200, `DMAS_RESP_OK);
    wr(`DMAS_MSKL_OFF, 32'hFF, `DMAS_RESP_OK);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      ctrl <= 20'h0C;
      c <= cv[i];
      at(1);
      chk("p", p, cv[i]);
      chk("flags", {overflow, underflow, pattern_bar, pattern_match}, ef[i]);
    end
    wr(`DMAS_CFG_OFF, 32'h240, `DMAS_RESP_OK);
    @(posedge aclk);
    c <= 48'h5A;
    at(1);
    chk("match", pattern_match, 1'h1);
    at(1);
    chk("p", p, 48'h0);
    $display("t_pat done");
  endtask

  task t_ctl();
    wr(`DMAS_CFG_OFF, 32'h200, `DMAS_RESP_OK);
    @(posedge aclk);
    ctrl <= 20'h1010;
    at(2);
    chk("p", p, 48'h6);
    @(posedge aclk);
    ctrl <= 20'h0C;
    c <= 48'h77;
    at(1);
    en <= 1'h0;
    c <= 48'h11;
    at(2);
    chk("p", p, 48'h77);
    en <= 1'h1;
    rst_p <= 1'h1;
    at(1);
    chk("p", p, 48'h0);
    rst_p <= 1'h0;
    at(2);
    chk("pcout", pcout, 48'h11);
    rst <= 1'h1;
    at(1);
    chk("p", p, 48'h0);
    chk("sign", multsign_out, 1'h0);
    rst <= 1'h0;
    $display("t_ctl done");
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    mul(32'h200, 20'h01, 30'h3, 18'h5, 25'h0, 2, 48'hF);
    mul(32'h5600, 20'h01, 30'h3, 18'h5, 25'h0, 3, 48'hF);
    mul(32'h203, 20'h01, 30'h0, 18'h0, 25'h0, 2, 48'h2A);
    mul(32'h220, 20'h01, 30'h2, 18'h4, 25'h3, 2, 48'h14);
    mul(32'h220, 20'h40001, 30'h2, 18'h4, 25'h3, 2, 48'h4);
    mul(32'h210, 20'h03, 30'h1, 18'h2, 25'h0, 2, 48'h40002);
    mul(32'h210, 20'h01, 30'h1, 18'h2, 25'h0, 2, 48'h2);
    $display("t_mul done");
    t_simd();
    t_pat();
    t_ctl();
    give_verdict();
  end
endmodule
